// ### fpt_regs.svh
// register offsets, reset values and timing counts of the fan pwm and tach block
`ifndef FPT_REGS_SVH
`define FPT_REGS_SVH
`define FPT_SMB_ADDR 7'h2A
`define FPT_OFS_TEMP_HI 8'h01
`define FPT_OFS_TEMP_LO 8'h10
`define FPT_OFS_OFFSET_HI 8'h11
`define FPT_OFS_OFFSET_LO 8'h12
`define FPT_OFS_TACH_LO 8'h46
`define FPT_OFS_TACH_HI 8'h47
`define FPT_OFS_CONFIG 8'h4A
`define FPT_OFS_DRIVE 8'h4C
`define FPT_OFS_FREQ 8'h4D
`define FPT_OFS_LUT_FIRST 8'h50
`define FPT_OFS_LUT_LAST 8'h5F
`define FPT_CFG_LUT_EN_BIT 0
`define FPT_RST_BYTE 8'h00
`define FPT_RST_FREQ 8'h14
`define FPT_RST_TACH 16'hFFFF
`define FPT_RD_UNMAPPED 8'hFF
`define FPT_CLK_HZ 25000000
`define FPT_TACH_CLK_HZ 90000
`define FPT_PWM_TICK_HZ 100000
`define FPT_TACH_DIV 9'((`FPT_CLK_HZ) / (`FPT_TACH_CLK_HZ))
`define FPT_PWM_DIV 9'((`FPT_CLK_HZ) / (`FPT_PWM_TICK_HZ))
`endif

// ### fpt_pkg.sv
// types shared by the fan pwm and tach block
package fpt_pkg;
  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } fpt_wr_t;
  typedef enum logic [3:0] {
    SMB_IDLE = 4'h0,
    SMB_ADDR = 4'h1,
    SMB_ACK_ADDR = 4'h2,
    SMB_CMD = 4'h3,
    SMB_ACK_CMD = 4'h4,
    SMB_WDATA = 4'h5,
    SMB_ACK_DATA = 4'h6,
    SMB_RDATA = 4'h7,
    SMB_RACK = 4'h8,
    SMB_RLOAD = 4'h9
  } fpt_smb_state_t;
endpackage

// ### fpt_smbus_slave.sv
// smbus byte read/write slave with a command pointer
`timescale 1ns/1ns
`include "fpt_regs.svh"
module fpt_smbus_slave import fpt_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output fpt_wr_t wr_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  logic scl_reg;
  logic sda_reg;
  fpt_smb_state_t state_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic [7:0] cmd_reg;
  logic rw_reg;
  logic oe_reg;
  fpt_wr_t wr_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_i & ~scl_reg;
  assign scl_fall = ~scl_i & scl_reg;
  assign start_seen = scl_i & scl_reg & sda_reg & ~sda_i;
  assign stop_seen = scl_i & scl_reg & ~sda_reg & sda_i;
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign wr_o = wr_reg;
  assign rd_addr_o = cmd_reg;

  // previous line levels for edge and start/stop detection
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
    end
  end

  // bus protocol engine
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= SMB_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      cmd_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= '0;
    end else begin
      wr_reg.strobe <= 1'b0;
      if (start_seen) begin
        state_reg <= SMB_ADDR;
        cnt_reg <= 4'h0;
        oe_reg <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= SMB_IDLE;
        oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          SMB_ADDR, SMB_CMD, SMB_WDATA: begin
            if (scl_rise && cnt_reg != 4'h8) begin
              sh_reg <= {sh_reg[6:0], sda_i};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              cnt_reg <= 4'h0;
              oe_reg <= 1'b1;
              if (state_reg == SMB_ADDR) begin
                rw_reg <= sh_reg[0];
                if (sh_reg[7:1] == `FPT_SMB_ADDR) begin
                  state_reg <= SMB_ACK_ADDR;
                end else begin
                  oe_reg <= 1'b0;
                  state_reg <= SMB_IDLE;
                end
              end else if (state_reg == SMB_CMD) begin
                cmd_reg <= sh_reg;
                state_reg <= SMB_ACK_CMD;
              end else begin
                wr_reg <= '{strobe: 1'b1, addr: cmd_reg, data: sh_reg};
                state_reg <= SMB_ACK_DATA;
              end
            end
          end
          SMB_ACK_ADDR: begin
            if (scl_fall) begin
              if (rw_reg) begin
                sh_reg <= rd_data_i;
                oe_reg <= ~rd_data_i[7];
                state_reg <= SMB_RDATA;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= SMB_CMD;
              end
            end
          end
          SMB_ACK_CMD, SMB_ACK_DATA: begin
            if (scl_fall) begin
              oe_reg <= 1'b0;
              if (state_reg == SMB_ACK_DATA) begin
                cmd_reg <= cmd_reg + 8'h01;
              end
              state_reg <= SMB_WDATA;
            end
          end
          SMB_RDATA: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                oe_reg <= 1'b0;
                cnt_reg <= 4'h0;
                state_reg <= SMB_RACK;
              end else begin
                oe_reg <= ~sh_reg[6];
                sh_reg <= {sh_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          SMB_RACK: begin
            if (scl_rise) begin
              if (sda_i) begin
                state_reg <= SMB_IDLE;
              end else begin
                cmd_reg <= cmd_reg + 8'h01;
                state_reg <= SMB_RLOAD;
              end
            end
          end
          SMB_RLOAD: begin
            if (scl_fall) begin
              sh_reg <= rd_data_i;
              oe_reg <= ~rd_data_i[7];
              state_reg <= SMB_RDATA;
            end
          end
          default: begin
            state_reg <= SMB_IDLE;
          end
        endcase
      end
    end
  end
endmodule // fpt_smbus_slave

// ### fpt_fan_ctrl.sv
// fan pwm drive, temperature lookup curve, offset correction and tach period counter
// What this block does
// - pwm duty equals value over twice the frequency setting
// - sixteen-slot table gives eight-step temperature curve
// - signed offset added to every remote reading
// - count 90 kHz periods per two tach pulses
// - count split low byte then high byte
`timescale 1ns/1ns
`include "fpt_regs.svh"
module fpt_fan_ctrl import fpt_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic smb_clk_i,
  input wire logic smb_data_i,
  output logic smb_data_o,
  output logic smb_data_oe_o,
  input wire logic tach_i,
  input wire logic [15:0] remote_temp_raw_i,
  output logic [15:0] remote_temp_o,
  output logic pwm_o
);
  fpt_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] offset_hi_reg;
  logic [7:0] offset_lo_reg;
  logic [7:0] drive_reg;
  logic [7:0] freq_reg;
  logic [7:0] config_reg;
  logic [7:0] lut_reg [0:15];
  logic [15:0] temp_reg;
  logic [8:0] pwm_div_reg;
  logic [8:0] tach_div_reg;
  logic pwm_tick;
  logic tach_tick;
  logic [8:0] pwm_cnt_reg;
  logic [8:0] period;
  logic [7:0] duty;
  logic [7:0] lut_pwm;
  logic [7:0] hit;
  logic tach_q_reg;
  logic tach_rise;
  logic half_reg;
  logic [15:0] tach_cnt_reg;
  logic [15:0] tach_reg;

  fpt_smbus_slave u_smbus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .scl_i(smb_clk_i),
    .sda_i(smb_data_i),
    .sda_o(smb_data_o),
    .sda_oe_o(smb_data_oe_o),
    .wr_o(wr),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  // writable control registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      offset_hi_reg <= `FPT_RST_BYTE;
      offset_lo_reg <= `FPT_RST_BYTE;
      drive_reg <= `FPT_RST_BYTE;
      freq_reg <= `FPT_RST_FREQ;
      config_reg <= `FPT_RST_BYTE;
    end else if (wr.strobe) begin
      case (wr.addr)
        `FPT_OFS_OFFSET_HI: offset_hi_reg <= wr.data;
        `FPT_OFS_OFFSET_LO: offset_lo_reg <= wr.data;
        `FPT_OFS_DRIVE: drive_reg <= wr.data;
        `FPT_OFS_FREQ: freq_reg <= wr.data;
        `FPT_OFS_CONFIG: config_reg <= wr.data;
        default: begin
        end
      endcase
    end
  end

  // curve slots: even slot is a threshold, odd slot its pwm value
  for (genvar i = 0; i < 16; i++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        lut_reg[i] <= `FPT_RST_BYTE;
      end else if (wr.strobe && wr.addr == (`FPT_OFS_LUT_FIRST + 8'(i))) begin
        lut_reg[i] <= wr.data;
      end
    end
  end

  for (genvar s = 0; s < 8; s++) begin : g_step
    assign hit[s] = $signed(temp_reg[15:8]) >= $signed(lut_reg[2 * s]);
  end

  // highest step whose threshold is reached; below the first step the fan is off
  always_comb begin
    lut_pwm = 8'h00;
    for (int s = 0; s < 8; s++) begin
      if (hit[s]) begin
        lut_pwm = lut_reg[2 * s + 1];
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_data = `FPT_RD_UNMAPPED;
    case (rd_addr)
      `FPT_OFS_TEMP_HI: rd_data = temp_reg[15:8];
      `FPT_OFS_TEMP_LO: rd_data = temp_reg[7:0];
      `FPT_OFS_OFFSET_HI: rd_data = offset_hi_reg;
      `FPT_OFS_OFFSET_LO: rd_data = offset_lo_reg;
      `FPT_OFS_TACH_LO: rd_data = tach_reg[7:0];
      `FPT_OFS_TACH_HI: rd_data = tach_reg[15:8];
      `FPT_OFS_CONFIG: rd_data = config_reg;
      `FPT_OFS_DRIVE: rd_data = drive_reg;
      `FPT_OFS_FREQ: rd_data = freq_reg;
      default: begin
        if (rd_addr >= `FPT_OFS_LUT_FIRST && rd_addr <= `FPT_OFS_LUT_LAST) begin
          rd_data = lut_reg[rd_addr[3:0]];
        end
      end
    endcase
  end

  // offset-corrected remote temperature
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      temp_reg <= 16'h0000;
    end else begin
      temp_reg <= remote_temp_raw_i + {offset_hi_reg, offset_lo_reg};
    end
  end
  assign remote_temp_o = temp_reg;

  // rate dividers for the pwm count and the tach clock
  assign pwm_tick = pwm_div_reg == (`FPT_PWM_DIV - 9'h001);
  assign tach_tick = tach_div_reg == (`FPT_TACH_DIV - 9'h001);
  always_ff @(posedge clk_i) begin
    if (reset_i || pwm_tick) begin
      pwm_div_reg <= 9'h000;
    end else begin
      pwm_div_reg <= pwm_div_reg + 9'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i || tach_tick) begin
      tach_div_reg <= 9'h000;
    end else begin
      tach_div_reg <= tach_div_reg + 9'h001;
    end
  end

  // pwm generator
  assign period = {freq_reg, 1'b0};
  assign duty = config_reg[`FPT_CFG_LUT_EN_BIT] ? lut_pwm : drive_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_cnt_reg <= 9'h000;
    end else if (pwm_tick) begin
      if (pwm_cnt_reg >= period - 9'h001 || period == 9'h000) begin
        pwm_cnt_reg <= 9'h000;
      end else begin
        pwm_cnt_reg <= pwm_cnt_reg + 9'h001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= (period != 9'h000) && ({1'b0, duty} >= period || {1'b0, duty} > pwm_cnt_reg);
    end
  end

  // tach period counter over two pulses, saturating when the fan stalls
  assign tach_rise = tach_i & ~tach_q_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tach_q_reg <= 1'b0;
      half_reg <= 1'b0;
      tach_cnt_reg <= 16'h0000;
      tach_reg <= `FPT_RST_TACH;
    end else begin
      tach_q_reg <= tach_i;
      if (tach_rise) begin
        half_reg <= ~half_reg;
      end
      if (tach_rise && half_reg) begin
        tach_reg <= tach_cnt_reg;
        tach_cnt_reg <= 16'h0000;
      end else if (tach_tick && tach_cnt_reg != 16'hFFFF) begin
        tach_cnt_reg <= tach_cnt_reg + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  pwm_full_a: assert property ((period != 9'h000 && {1'b0, duty} >= period) |=> pwm_o)
    else $error("pwm not high at full duty");
  pwm_zero_a: assert property ((duty == 8'h00) |=> !pwm_o)
    else $error("pwm high at zero duty");
  pwm_wrap_a: assert property ((pwm_tick && period != 9'h000 && pwm_cnt_reg == period - 9'h001) |=> pwm_cnt_reg == 9'h000)
    else $error("pwm period not twice frequency");
  offset_sum_a: assert property (##1 temp_reg == 16'($past(remote_temp_raw_i) + {$past(offset_hi_reg), $past(offset_lo_reg)}))
    else $error("remote temperature offset not applied");
  lut_write_a: assert property ((wr.strobe && wr.addr >= `FPT_OFS_LUT_FIRST && wr.addr <= `FPT_OFS_LUT_LAST) |=> lut_reg[$past(wr.addr[3:0])] == $past(wr.data))
    else $error("curve slot not written");
  lut_pick_a: assert property ((config_reg[`FPT_CFG_LUT_EN_BIT] && hit[7]) |-> duty == lut_reg[15])
    else $error("top curve step not applied");
  tach_latch_a: assert property ((tach_rise && half_reg) |=> tach_reg == $past(tach_cnt_reg) && tach_cnt_reg == 16'h0000)
    else $error("tach count not latched per revolution");
  tach_one_a: assert property ((tach_rise && !half_reg) |=> $stable(tach_reg))
    else $error("tach latched after one pulse");
  tach_split_a: assert property ((rd_addr == `FPT_OFS_TACH_HI) |-> rd_data == tach_reg[15:8])
    else $error("tach high byte misplaced");
  tach_div_a: assert property (tach_tick |=> !tach_tick [*8])
    else $error("tach clock too fast");

  pwm_mid_c: cover property (pwm_o ##1 !pwm_o);
  lut_used_c: cover property (config_reg[`FPT_CFG_LUT_EN_BIT] && hit[3] && !hit[4]);
  tach_done_c: cover property (tach_rise && half_reg && tach_cnt_reg > 16'h0002);
  offset_neg_c: cover property (offset_hi_reg[7] && wr.strobe);
endmodule // fpt_fan_ctrl

// ### fpt_fan_model.sv
// cooling fan model: tach pulses while spinning, line low while stopped
`timescale 1ns/1ns
module fpt_fan_model #(
  parameter int REV_CLK = 11080
) (
  input wire logic clk_i,
  input wire logic spin_i,
  output logic tach_o
);
  int cnt = 0;
  // one pulse every half revolution
  always @(posedge clk_i) begin
    cnt <= (!spin_i || cnt == REV_CLK / 2 - 1) ? 0 : cnt + 1;
  end
  assign tach_o = spin_i && (cnt < REV_CLK / 4);
endmodule // fpt_fan_model

// ### fpt_fan_ctrl_tb.sv
// self-checking bench for the fan pwm and tach block
`timescale 1ns/1ns
`include "fpt_regs.svh"
module fpt_fan_ctrl_tb;
  import fpt_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic scl = 1'b1;
  logic m_low = 1'b0;
  logic spin = 1'b0;
  logic [15:0] raw = 16'h0000;
  logic sda_o, sda_oe, tach, pwm;
  logic [15:0] temp;
  logic [7:0] d, hi;
  int n_mismatch = 0;
  int cmp_count = 0;
  int hc;
  int rpm;
  logic [7:0] dv[5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05};
  logic [15:0] ev[5] = '{16'h0000, 16'h01F4, 16'h05DC, 16'h07D0, 16'h07D0};
  logic [15:0] tv[4] = '{16'h0A00, 16'h1D80, 16'h1E00, 16'h5F00};
  logic [15:0] cv[4] = '{16'h0000, 16'h01F4, 16'h03E8, 16'h07D0};
  // open-drain data wire: low when either party pulls
  wire sda = ~(sda_oe | m_low);
  always #20 clk_i = ~clk_i;
  fpt_fan_ctrl uut (.clk_i(clk_i), .reset_i(reset_i), .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(sda_o),
    .smb_data_oe_o(sda_oe), .tach_i(tach), .remote_temp_raw_i(raw), .remote_temp_o(temp), .pwm_o(pwm));
  fpt_fan_model #(.REV_CLK(11080)) fan (.clk_i(clk_i), .spin_i(spin), .tach_o(tach));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one smbus bit, low phase of 7 and high phase of 6 clk, 520 ns per bit
  task automatic sbit(input logic b, output logic s);
    m_low = ~b;
    tick(5);
    scl = 1'b1;
    tick(3);
    s = sda;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start();
    m_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    m_low = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    m_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    m_low = 1'b0;
    tick(5);
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) sbit(v[i], s);
    sbit(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic k1, k2, k3;
    start();
    tx({`FPT_SMB_ADDR, 1'b0}, k1);
    tx(ofs, k2);
    tx(v, k3);
    stop();
    check({13'h0000, k1, k2, k3}, 16'h0007);
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic k;
    start();
    tx({`FPT_SMB_ADDR, 1'b0}, k);
    tx(ofs, k);
    stop();
    start();
    tx({`FPT_SMB_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) sbit(1'b1, v[i]);
    sbit(1'b1, k);
    stop();
  endtask
  // high cycles over two 1000-clk pwm periods, after one period to settle
  task automatic measure();
    tick(1000);
    hc = 0;
    repeat (2000) begin
      @(negedge clk_i);
      hc += (pwm === 1'b1) ? 1 : 0;
    end
    tick(1);
  endtask
  initial begin
    #3800000;
    n_mismatch++;
    conclude();
  end
  initial begin
    tick(4);
    reset_i = 1'b0;
    tick(2);
    rd(`FPT_OFS_FREQ, d);
    check({8'h00, d}, 16'h0014);
    check({15'h0000, sda_o}, 16'h0000);
    rd(`FPT_OFS_DRIVE, d);
    check({8'h00, d}, 16'h0000);
    rd(8'h60, d);
    check({8'h00, d}, {8'h00, `FPT_RD_UNMAPPED});
    wr(`FPT_OFS_TACH_LO, 8'h12);
    rd(`FPT_OFS_TACH_LO, d);
    rd(`FPT_OFS_TACH_HI, hi);
    check({hi, d}, `FPT_RST_TACH);
    raw = 16'h1900;
    wr(`FPT_OFS_OFFSET_HI, 8'hFE);
    wr(`FPT_OFS_OFFSET_LO, 8'h80);
    tick(3);
    check(temp, 16'h1780);
    rd(`FPT_OFS_TEMP_HI, d);
    check({8'h00, d}, 16'h0017);
    rd(`FPT_OFS_OFFSET_HI, d);
    check({8'h00, d}, 16'h00FE);
    wr(`FPT_OFS_FREQ, 8'h02);
    for (int i = 0; i < 5; i++) begin
      wr(`FPT_OFS_DRIVE, dv[i]);
      measure();
      check(hc[15:0], ev[i]);
    end
    wr(`FPT_OFS_OFFSET_HI, 8'h00);
    wr(`FPT_OFS_OFFSET_LO, 8'h00);
    // thresholds 20..90 ascending, pwm values 1,2,3,4 repeated
    for (int k = 0; k < 8; k++) begin
      wr(`FPT_OFS_LUT_FIRST + 8'(2 * k), 8'(20 + 10 * k));
      wr(`FPT_OFS_LUT_FIRST + 8'(2 * k + 1), 8'(k % 4 + 1));
    end
    wr(`FPT_OFS_CONFIG, 8'h01);
    for (int i = 0; i < 4; i++) begin
      raw = tv[i];
      measure();
      check(hc[15:0], cv[i]);
    end
    spin = 1'b1;
    tick(33740);
    rd(`FPT_OFS_TACH_LO, d);
    rd(`FPT_OFS_TACH_HI, hi);
    check({15'h0000, d >= 8'h27 && d <= 8'h29}, 16'h0001);
    check({8'h00, hi}, 16'h0000);
    rpm = 5400000 / {hi, d};
    check({15'h0000, rpm >= 131000 && rpm <= 139000}, 16'h0001);
    conclude();
  end
endmodule // fpt_fan_ctrl_tb
